// >>> design/itd_dispatcher.sv
`timescale 1ns/1ps
module itd_dispatcher
	import itd_pkg::*;
#(
	parameter int MS_CYC = ONE_MS_CYCLES,
	parameter int TENTH_CYC = TENTH_MS_CYCLES
) (
	// Clock, reset and freeze
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Memory word access
	input wire logic [8:0] mem_addr,
	input wire logic mem_wr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	// Setup and operating control
	input wire logic err_detect_disable,
	input wire logic run_start,
	// Interrupt sources
	input wire logic power_fail_pin,
	input wire logic [PIN_COUNT-1:0] io_req_pin,
	input wire logic [SCHED_COUNT-1:0] sched_req,
	input wire logic ext_req,
	input wire logic [7:0] ext_task,
	// Task execution engine
	input wire logic task_done,
	input wire logic clear_pending_irq_op,
	input wire logic [7:0] clear_task,
	input wire itd_op_type unit_op,
	input wire logic legacy_refresh,
	output itd_disp_type disp,
	output logic abort,
	output logic po_terminate,
	output logic cpu_reset,
	output logic op_ack,
	output logic op_refused,
	output logic irq_task_error_flag
);

	logic [1:0] rst_sync_q;
	logic rst_i_n;
	logic pf_m_q, pf_s_q;
	logic [PIN_COUNT-1:0] io_m_q, io_s_q, io_prev_q;
	logic [15:0] setup_q, err_word_q, max_time_q, max_task_q, rdata_q;
	itd_state_type state_q;
	logic [7:0] cur_task_q;
	itd_disp_type disp_q;
	logic abort_q, term_q, cpu_reset_q, ack_q, refused_q, flag_q;
	logic [EXT_COUNT-1:0] ext_pend_q;
	logic [PIN_COUNT-1:0] pin_pend_q;
	logic [SCHED_COUNT-1:0] sch_pend_q;
	logic [16:0] ms_pre_q;
	logic [7:0] ms_cnt_q;
	logic [13:0] tenth_pre_q;
	logic [15:0] elapsed_q;
	logic ovr_done_q;
	logic busy, ms_run, po_recog, po_expire, dispatch_go, err_en;
	logic overrun, conflict, done_evt, any_pend;
	logic [7:0] delay_code, sel_task;
	logic [3:0] po_limit;
	logic pin_found, ext_found, sch_found;
	logic [4:0] pin_idx;
	logic [7:0] ext_idx;
	logic [0:0] sch_idx;

	// Reset release through two flops; ce freezes it like all other state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'b00;
		end else if (ce) begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_i_n = rst_sync_q[1];

	// Pin synchronisers; edge detect looks only at the second stage
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			pf_m_q <= 1'b0;
			pf_s_q <= 1'b0;
			io_m_q <= '0;
			io_s_q <= '0;
			io_prev_q <= '0;
		end else if (ce) begin
			pf_m_q <= power_fail_pin;
			pf_s_q <= pf_m_q;
			io_m_q <= io_req_pin;
			io_s_q <= io_m_q;
			io_prev_q <= io_s_q;
		end
	end

	// Delay codes above the documented top are clamped to 10 ms
	assign delay_code = (setup_q[PO_DELAY_LSB +: PO_DELAY_W] > PO_DELAY_MAX) ?
		PO_DELAY_MAX : setup_q[PO_DELAY_LSB +: PO_DELAY_W];
	assign po_limit = PO_WINDOW_MS - delay_code[3:0];
	assign busy = (state_q == ST_RUN) || (state_q == ST_PWR);
	assign err_en = !err_detect_disable;

	// Power loss counts only after the extra delay has run out
	assign po_recog = pf_s_q && ((state_q == ST_IDLE) ||
		(state_q == ST_RUN)) && (ms_cnt_q >= delay_code);
	assign po_expire = (state_q == ST_PWR) &&
		(ms_cnt_q >= {4'h0, po_limit});
	assign ms_run = (pf_s_q && !po_recog) || (state_q == ST_PWR);

	// Millisecond timer, shared by the delay and the power-off window
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ms_pre_q <= '0;
			ms_cnt_q <= '0;
		end else if (ce) begin
			if (!ms_run) begin
				ms_pre_q <= '0;
				ms_cnt_q <= '0;
			end else if (ms_pre_q == 17'(MS_CYC - 1)) begin
				ms_pre_q <= '0;
				if (ms_cnt_q != 8'hff) begin
					ms_cnt_q <= ms_cnt_q + 8'h01;
				end
			end else begin
				ms_pre_q <= ms_pre_q + 17'h00001;
			end
		end
	end

	// Priority encoders, one per source
	itd_lowest_first #(.W(PIN_COUNT), .IW(5)) u_pin_enc (
		.req(pin_pend_q),
		.found(pin_found),
		.idx(pin_idx)
	);
	itd_lowest_first #(.W(EXT_COUNT), .IW(8)) u_ext_enc (
		.req(ext_pend_q),
		.found(ext_found),
		.idx(ext_idx)
	);
	itd_lowest_first #(.W(SCHED_COUNT), .IW(1)) u_sch_enc (
		.req(sch_pend_q),
		.found(sch_found),
		.idx(sch_idx)
	);

	// Source order pin, external, scheduled; lowest number within each
	always_comb begin
		sel_task = TASK_SCHED_BASE + {7'h00, sch_idx};
		if (pin_found) begin
			sel_task = TASK_PIN_BASE + {3'h0, pin_idx};
		end else if (ext_found) begin
			sel_task = ext_idx;
		end
	end
	assign any_pend = pin_found || ext_found || sch_found;
	// No nesting: a new task is taken only from idle
	assign dispatch_go = (state_q == ST_IDLE) && any_pend && !po_recog;

	// Pending bits per task; a request for the running task is dropped
	genvar g;
	generate
		for (g = 0; g < EXT_COUNT; g++) begin : g_ext
			always_ff @(posedge clk or negedge rst_i_n) begin
				if (!rst_i_n) begin
					ext_pend_q[g] <= 1'b0;
				end else if (ce) begin
					if (run_start ||
						(dispatch_go && sel_task == 8'(g))) begin
						ext_pend_q[g] <= 1'b0;
					end else if (ext_req && ext_task == 8'(g) &&
						!(busy && cur_task_q == 8'(g))) begin
						ext_pend_q[g] <= 1'b1;
					end
				end
			end
		end
		for (g = 0; g < PIN_COUNT; g++) begin : g_pin
			always_ff @(posedge clk or negedge rst_i_n) begin
				if (!rst_i_n) begin
					pin_pend_q[g] <= 1'b0;
				end else if (ce) begin
					if (run_start || (dispatch_go &&
						sel_task == TASK_PIN_BASE + 8'(g))) begin
						pin_pend_q[g] <= 1'b0;
					end else if (io_s_q[g] && !io_prev_q[g] && !(busy &&
						cur_task_q == TASK_PIN_BASE + 8'(g))) begin
						pin_pend_q[g] <= 1'b1;
					end else if (clear_pending_irq_op && busy &&
						clear_task == TASK_PIN_BASE + 8'(g)) begin
						pin_pend_q[g] <= 1'b0;
					end
				end
			end
		end
		for (g = 0; g < SCHED_COUNT; g++) begin : g_sch
			always_ff @(posedge clk or negedge rst_i_n) begin
				if (!rst_i_n) begin
					sch_pend_q[g] <= 1'b0;
				end else if (ce) begin
					if (run_start || (dispatch_go &&
						sel_task == TASK_SCHED_BASE + 8'(g))) begin
						sch_pend_q[g] <= 1'b0;
					end else if (sched_req[g] && !(busy &&
						cur_task_q == TASK_SCHED_BASE + 8'(g))) begin
						sch_pend_q[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// Dispatch state machine; power-off pre-empts and never returns
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			state_q <= ST_IDLE;
			cur_task_q <= 8'h00;
			disp_q <= '0;
			abort_q <= 1'b0;
			term_q <= 1'b0;
			cpu_reset_q <= 1'b0;
		end else if (ce) begin
			abort_q <= 1'b0;
			term_q <= 1'b0;
			case (state_q)
				ST_IDLE, ST_RUN: begin
					if (po_recog) begin
						abort_q <= (state_q == ST_RUN);
						if (setup_q[PO_EN_BIT]) begin
							state_q <= ST_PWR;
							cur_task_q <= TASK_POWER_OFF;
							disp_q <= '{1'b1, 1'b1, TASK_POWER_OFF};
						end else begin
							state_q <= ST_HALT;
							disp_q <= '0;
						end
					end else if (state_q == ST_IDLE && dispatch_go) begin
						state_q <= ST_RUN;
						cur_task_q <= sel_task;
						disp_q <= '{1'b1, 1'b0, sel_task};
					end else if (state_q == ST_RUN && task_done) begin
						state_q <= ST_IDLE;
						disp_q <= '0;
					end
				end
				ST_PWR: begin
					if (task_done || po_expire) begin
						term_q <= po_expire && !task_done;
						state_q <= ST_HALT;
						disp_q <= '0;
					end
				end
				ST_HALT: begin
					cpu_reset_q <= 1'b1;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Task duration in 0.1 ms units, restarted at each dispatch
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			tenth_pre_q <= '0;
			elapsed_q <= '0;
		end else if (ce) begin
			if (dispatch_go || po_recog) begin
				tenth_pre_q <= '0;
				elapsed_q <= '0;
			end else if (busy) begin
				if (tenth_pre_q == 14'(TENTH_CYC - 1)) begin
					tenth_pre_q <= '0;
					// Saturates rather than wrapping into a false short time
					if (elapsed_q != 16'hffff) begin
						elapsed_q <= elapsed_q + 16'h0001;
					end
				end else begin
					tenth_pre_q <= tenth_pre_q + 14'h0001;
				end
			end
		end
	end

	// Longest time and its task; start of operation clears, events win
	assign done_evt = busy && (task_done || po_expire);
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			max_time_q <= WORD_RESET;
			max_task_q <= WORD_RESET;
		end else if (ce) begin
			if (run_start) begin
				max_time_q <= WORD_RESET;
				max_task_q <= WORD_RESET;
			end
			if (dispatch_go || po_recog) begin
				max_task_q[TASK_MARK_BIT] <= 1'b1;
			end
			if (done_evt && (elapsed_q > max_time_q ||
				max_time_q == WORD_RESET)) begin
				max_time_q <= elapsed_q;
				max_task_q <= {1'b1, 7'h00, cur_task_q};
			end
		end
	end

	// Overrun is flagged once per task; a conflict takes precedence
	assign overrun = busy && legacy_refresh && !ovr_done_q &&
		(elapsed_q > OVERRUN_TENTHS);
	assign conflict = busy && unit_op.valid && unit_op.unit_busy;
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ovr_done_q <= 1'b0;
			flag_q <= 1'b0;
			err_word_q <= WORD_RESET;
			ack_q <= 1'b0;
			refused_q <= 1'b0;
		end else if (ce) begin
			ack_q <= unit_op.valid;
			refused_q <= conflict;
			if (dispatch_go || po_recog) begin
				ovr_done_q <= 1'b0;
			end else if (overrun) begin
				ovr_done_q <= 1'b1;
			end
			if (run_start) begin
				flag_q <= 1'b0;
				err_word_q <= WORD_RESET;
			end
			if (err_en && conflict) begin
				flag_q <= 1'b1;
				err_word_q <= {1'b1, 3'h0, unit_op.unit};
			end else if (err_en && overrun) begin
				flag_q <= 1'b1;
				err_word_q <= {1'b0, 7'h00, cur_task_q};
			end
		end
	end

	// Setup word write and registered read-back; unmapped reads give zero
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			setup_q <= PO_SETUP_RESET;
			rdata_q <= WORD_RESET;
		end else if (ce) begin
			if (mem_wr && mem_addr == ADDR_PO_SETUP) begin
				setup_q <= mem_wdata;
			end
			case (mem_addr)
				ADDR_PO_SETUP: rdata_q <= setup_q;
				ADDR_ERR_TASK: rdata_q <= err_word_q;
				ADDR_MAX_TIME: rdata_q <= max_time_q;
				ADDR_MAX_TASK: rdata_q <= max_task_q;
				default: rdata_q <= WORD_RESET;
			endcase
		end
	end

	// Outputs straight from flops
	assign mem_rdata = rdata_q;
	assign disp = disp_q;
	assign abort = abort_q;
	assign po_terminate = term_q;
	assign cpu_reset = cpu_reset_q;
	assign op_ack = ack_q;
	assign op_refused = refused_q;
	assign irq_task_error_flag = flag_q;

endmodule : itd_dispatcher

// >>> design/itd_pkg.sv
package itd_pkg;

	// Clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int TENTH_MS_NS = 100000;
	localparam int ONE_MS_NS = 1000000;
	localparam int TENTH_MS_CYCLES = TENTH_MS_NS / CLK_PERIOD_NS;
	localparam int ONE_MS_CYCLES = ONE_MS_NS / CLK_PERIOD_NS;
	localparam int TENTHS_PER_MS = ONE_MS_NS / TENTH_MS_NS;

	// Power-off window and overrun limit, in ms; overrun also in 0.1 ms
	localparam logic [3:0] PO_WINDOW_MS = 4'ha;
	localparam int OVERRUN_MS = 10;
	localparam logic [15:0] OVERRUN_TENTHS = 16'(OVERRUN_MS * TENTHS_PER_MS);

	// Word offsets of the memory-mapped words
	localparam logic [8:0] ADDR_PO_SETUP = 9'h0e1;
	localparam logic [8:0] ADDR_ERR_TASK = 9'h1aa;
	localparam logic [8:0] ADDR_MAX_TIME = 9'h1b8;
	localparam logic [8:0] ADDR_MAX_TASK = 9'h1b9;

	// Field positions and reset values
	localparam int PO_EN_BIT = 15;
	localparam int PO_DELAY_LSB = 0;
	localparam int PO_DELAY_W = 8;
	localparam logic [7:0] PO_DELAY_MAX = 8'h0a;
	localparam int TASK_MARK_BIT = 15;
	localparam int ERR_KIND_BIT = 15;
	localparam logic [15:0] PO_SETUP_RESET = 16'h0000;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// Task numbering
	localparam logic [7:0] TASK_POWER_OFF = 8'h01;
	localparam logic [7:0] TASK_SCHED_BASE = 8'h02;
	localparam logic [7:0] TASK_PIN_BASE = 8'h64;
	localparam int PIN_COUNT = 32;
	localparam int SCHED_COUNT = 2;
	localparam int EXT_COUNT = 256;

	// Dispatcher states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_PWR = 2'b10,
		ST_HALT = 2'b11
	} itd_state_type;

	// Unit refresh, read or write issued from an interrupt task
	typedef struct packed {
		logic valid;
		logic unit_busy;
		logic [11:0] unit;
	} itd_op_type;

	// Task handed to the execution engine
	typedef struct packed {
		logic valid;
		logic power_off;
		logic [7:0] task_num;
	} itd_disp_type;

endpackage : itd_pkg

// >>> design/itd_lowest_first.sv
`timescale 1ns/1ps
module itd_lowest_first #(
	parameter int W = 32,
	parameter int IW = 5
) (
	// Request vector
	input wire logic [W-1:0] req,
	// Lowest set position
	output logic found,
	output logic [IW-1:0] idx
);

	// Scan from the top so the lowest set bit is written last
	always_comb begin
		found = |req;
		idx = '0;
		for (int i = W - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = IW'(i);
			end
		end
	end

endmodule : itd_lowest_first

// >>> sim/itd_ext_unit.sv
`timescale 1ns/1ps
module itd_ext_unit (
	// Clock and bench command
	clk,
	go,
	num,
	// Request towards the CPU
	ext_req,
	ext_task
);
	input wire logic clk;
	input wire logic go;
	input wire logic [7:0] num;
	output logic ext_req;
	output logic [7:0] ext_task;
	logic [7:0] last_q;
	// Board raises its request once its data is stored; number preset
	// or computed by the bench acting as the board
	assign ext_req = go;
	assign ext_task = go ? num : ~last_q;
	// Released number lines show the inverse, never a stale copy
	always_ff @(posedge clk) begin
		if (go) last_q <= num;
	end
endmodule : itd_ext_unit

// >>> sim/itd_dispatcher_properties.sv
`timescale 1ns/1ps
module itd_dispatcher_properties
	import itd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Watched inputs
	input wire logic power_fail_pin,
	input wire logic ext_req,
	input wire logic task_done,
	input wire logic err_detect_disable,
	input wire itd_op_type unit_op,
	// Watched outputs
	input wire itd_disp_type disp,
	input wire logic abort,
	input wire logic po_terminate,
	input wire logic op_ack,
	input wire logic op_refused,
	input wire logic irq_task_error_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic pf_seen_q;
	// Sticky once supply fails, so the power-off switch is excused
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) pf_seen_q <= 1'b0;
		else if (power_fail_pin) pf_seen_q <= 1'b1;
	end
	property p_ext_go;
		ce && ext_req && !disp.valid && !pf_seen_q |-> ##2 disp.valid;
	endproperty
	a_ext_go: assert property (p_ext_go) else $error("ext not run");
	property p_no_nest;
		disp.valid && !task_done && !pf_seen_q && ce
			|=> disp.valid && $stable(disp.task_num);
	endproperty
	a_no_nest: assert property (p_no_nest) else $error("task nested");
	property p_done;
		disp.valid && !disp.power_off && task_done && ce |=> !disp.valid;
	endproperty
	a_done: assert property (p_done) else $error("task stuck");
	property p_ack;
		unit_op.valid && ce |=> op_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("no op ack");
	property p_refuse;
		unit_op.valid && unit_op.unit_busy && disp.valid && ce |=> op_refused;
	endproperty
	a_refuse: assert property (p_refuse) else $error("no refuse");
	property p_flag;
		$rose(irq_task_error_flag) |-> !$past(err_detect_disable);
	endproperty
	a_flag: assert property (p_flag) else $error("flag set");
	property p_abort;
		abort |-> ##[0:1] disp.valid && disp.power_off
			&& disp.task_num == TASK_POWER_OFF;
	endproperty
	a_abort: assert property (p_abort) else $error("bad abort");
	property p_po_cause;
		$rose(disp.power_off) |-> pf_seen_q;
	endproperty
	a_po_cause: assert property (p_po_cause) else $error("po start");
	property p_term;
		po_terminate |-> $past(disp.power_off);
	endproperty
	a_term: assert property (p_term) else $error("bad term");
	c_ext: cover property (ext_req ##2 disp.valid);
	c_refuse: cover property (op_refused);
	c_term: cover property (po_terminate);
endmodule : itd_dispatcher_properties

bind itd_dispatcher itd_dispatcher_properties itd_dispatcher_properties_inst (
	.clk, .rst_n, .ce, .power_fail_pin, .ext_req, .task_done,
	.err_detect_disable, .unit_op, .disp, .abort, .po_terminate, .op_ack,
	.op_refused, .irq_task_error_flag
);

// >>> sim/test_interrupt_task_dispatcher.sv
`timescale 1ns/1ps
module test_interrupt_task_dispatcher import itd_pkg::*;;
	localparam int MS = 20;
	localparam int TC = 4;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, mem_wr = 1'b0;
	logic [8:0] mem_addr = 9'h000;
	logic [15:0] mem_wdata = 16'h0000, mem_rdata, v;
	logic err_detect_disable = 1'b0, run_start = 1'b0, power_fail_pin = 1'b0;
	logic [31:0] io_req_pin = 32'h0;
	logic [1:0] sched_req = 2'h0;
	logic go = 1'b0, ext_req, task_done = 1'b0, legacy_refresh = 1'b0;
	logic clear_pending_irq_op = 1'b0;
	logic [7:0] num = 8'h00, ext_task, clear_task = 8'h00;
	itd_op_type unit_op = '0;
	itd_disp_type disp;
	logic abort, po_terminate, cpu_reset, op_ack, op_refused;
	logic irq_task_error_flag;
	int bad_count = 0;
	int tests_run = 0;
	int n;
	always #5 clk = ~clk;
	itd_dispatcher #(.MS_CYC(MS), .TENTH_CYC(TC)) itd_dispatcher_inst (
		.clk, .rst_n, .ce, .mem_addr, .mem_wr, .mem_wdata, .mem_rdata,
		.err_detect_disable, .run_start, .power_fail_pin, .io_req_pin,
		.sched_req, .ext_req, .ext_task, .task_done, .clear_pending_irq_op,
		.clear_task, .unit_op, .legacy_refresh, .disp, .abort, .po_terminate,
		.cpu_reset, .op_ack, .op_refused, .irq_task_error_flag
	);
	itd_ext_unit itd_ext_unit_inst (.clk, .go, .num, .ext_req, .ext_task);
	// Comparison and verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	// Word access, all tasks start and end at a falling edge
	task automatic rd(input logic [8:0] a, input logic [15:0] exp);
		mem_addr = a;
		@(negedge clk);
		check(mem_rdata, exp);
	endtask : rd
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		mem_addr = a;
		mem_wdata = d;
		mem_wr = 1'b1;
		@(negedge clk);
		mem_wr = 1'b0;
	endtask : wr
	// One edge passes after each request so back-to-back calls never
	// lower and raise the request in one time step
	task automatic ext(input logic [7:0] t);
		go = 1'b1;
		num = t;
		@(negedge clk);
		go = 1'b0;
		@(negedge clk);
	endtask : ext
	// Bounded wait: 0 dispatch, 1 abort, 2 window end
	task automatic wait_hi(input int sel, output int k);
		k = 0;
		while ((sel == 0 ? disp.valid : sel == 1 ? abort : po_terminate)
			!== 1'b1) begin
			@(negedge clk);
			k++;
			if (k > 400) begin
				bad_count++;
				finish_test();
			end
		end
	endtask : wait_hi
	task automatic start(input logic [7:0] t);
		wait_hi(0, n);
		check(16'(disp), {6'h0, 2'b10, t});
	endtask : start
	task automatic done();
		task_done = 1'b1;
		@(negedge clk);
		task_done = 1'b0;
	endtask : done
	// Every op here is issued while a task runs, so a busy unit is refused
	task automatic op(input logic [11:0] u, input logic busy);
		unit_op = {1'b1, busy, u};
		@(negedge clk);
		check(16'({op_ack, op_refused}), {14'h0, 1'b1, busy});
		unit_op = '0;
		@(negedge clk);
	endtask : op
	task automatic idle_check();
		repeat (5) @(negedge clk);
		check(16'(disp.valid), 16'h0);
	endtask : idle_check
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		// Reset values, read-only and unmapped words
		rd(ADDR_PO_SETUP, PO_SETUP_RESET);
		rd(ADDR_MAX_TASK, WORD_RESET);
		rd(ADDR_ERR_TASK, WORD_RESET);
		wr(ADDR_MAX_TIME, 16'hffff);
		rd(ADDR_MAX_TIME, WORD_RESET);
		rd(9'h0e2, 16'h0000);
		wr(ADDR_PO_SETUP, 16'h0002);
		rd(ADDR_PO_SETUP, 16'h0002);
		// Requests pile up behind a long task
		ext(8'h05);
		start(8'h05);
		ext(8'h09);
		ext(8'h08);
		ext(8'h05);
		io_req_pin = 32'h1;
		sched_req = 2'b01;
		@(negedge clk);
		sched_req = 2'b00;
		repeat (100) @(negedge clk);
		done();
		start(8'h64);
		done();
		start(8'h08);
		done();
		start(8'h09);
		done();
		start(8'h02);
		done();
		idle_check();
		// Shared number from two sources runs once
		sched_req = 2'b10;
		ext(8'h03);
		sched_req = 2'b00;
		start(8'h03);
		done();
		idle_check();
		// Clear drops the pin request but not the scheduled one
		ext(8'h20);
		start(8'h20);
		io_req_pin = 32'h3;
		sched_req = 2'b01;
		@(negedge clk);
		sched_req = 2'b00;
		repeat (4) @(negedge clk);
		clear_pending_irq_op = 1'b1;
		clear_task = 8'h65;
		@(negedge clk);
		clear_task = 8'h02;
		@(negedge clk);
		clear_pending_irq_op = 1'b0;
		done();
		start(8'h02);
		done();
		idle_check();
		mem_addr = ADDR_MAX_TIME;
		@(negedge clk);
		v = mem_rdata;
		check(16'(v >= 16'h18 && v <= 16'h1b), 16'h1);
		rd(ADDR_MAX_TASK, 16'h8005);
		// Conflicts with detection off, then on
		err_detect_disable = 1'b1;
		ext(8'h30);
		start(8'h30);
		op(12'h010, 1'b1);
		check(16'(irq_task_error_flag), 16'h0);
		rd(ADDR_ERR_TASK, 16'h0000);
		err_detect_disable = 1'b0;
		op(12'h011, 1'b0);
		op(12'h05f, 1'b1);
		done();
		check(16'(irq_task_error_flag), 16'h1);
		rd(ADDR_ERR_TASK, 16'h805f);
		// Overrun during legacy refresh
		legacy_refresh = 1'b1;
		ext(8'h06);
		start(8'h06);
		repeat (420) @(negedge clk);
		done();
		legacy_refresh = 1'b0;
		rd(ADDR_ERR_TASK, 16'h0006);
		rd(ADDR_MAX_TASK, 16'h8006);
		// Start of operation clears, first dispatch marks
		run_start = 1'b1;
		@(negedge clk);
		run_start = 1'b0;
		rd(ADDR_MAX_TIME, 16'h0000);
		rd(ADDR_MAX_TASK, 16'h0000);
		check(16'(irq_task_error_flag), 16'h0);
		ext(8'h07);
		start(8'h07);
		done();
		rd(ADDR_MAX_TASK, 16'h8007);
		// Power loss aborts a task; window is 10 ms less 2 ms delay
		wr(ADDR_PO_SETUP, 16'h8002);
		ext(8'h0a);
		start(8'h0a);
		power_fail_pin = 1'b1;
		wait_hi(1, n);
		check(16'(n >= 2 * MS && n <= 2 * MS + 6), 16'h1);
		@(negedge clk);
		check(16'(disp), {6'h0, 2'b11, TASK_POWER_OFF});
		wait_hi(2, n);
		check(16'(n >= 8 * MS - 4 && n <= 8 * MS + 4), 16'h1);
		repeat (2) @(negedge clk);
		check(16'(cpu_reset), 16'h1);
		// Mid-run reset with supply still low: setup back to disabled
		rst_n = 1'b0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (40) @(negedge clk);
		check(16'(disp), 16'h0000);
		check(16'(cpu_reset), 16'h1);
		finish_test();
	end
endmodule : test_interrupt_task_dispatcher
